// *** hdl/flash_host_consts.vh ***
/*
 Timing counts and identifier layout for the flash bus host controller.
 Assumes a 200 MHz controller clock; included by the host module only.
*/
`ifndef FLASH_HOST_CONSTS_VH
`define FLASH_HOST_CONSTS_VH
`define CLK_PERIOD_PS 5000
`define SLEEP_TIME_NS 150
`define SLEEP_CYC ((`SLEEP_TIME_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define RESET_LOW_NS 500
`define RESET_LOW_CYC ((`RESET_LOW_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define RESET_DONE_US 20
`define RESET_DONE_CYC ((`RESET_DONE_US * 1000000) / `CLK_PERIOD_PS)
`define ACC_DELAY_NS 70
`define ACC_DELAY_CYC ((`ACC_DELAY_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define WAKE_DELAY_NS 50
`define WAKE_DELAY_CYC ((`WAKE_DELAY_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define WE_LOW_CYC 8
`define WE_HIGH_CYC 8
`define BANK_LSB 16
`define BANK_MSB 18
`define ID_WORD_SELECT_BIT 0
`define ID_PAGE_BIT 1
`define ID_AUX_BIT 6
`define ID_VOLTAGE_ADDRESS_PIN 9
`define PARITY_DATA_BIT 7
`endif

// *** hdl/flash_bus_host.v ***
/*
 Host controller driving a dual-bank asynchronous NOR flash over its
 address, data and strobe pins: reads, command writes, identifier reads
 under the identifier high voltage request, hardware reset and standby.
 Assumes the board turns the pin enables into wire levels and that the
 flash keeps its own timing; data pins are sampled through two flops.
*/
`timescale 1ns/100ps
`include "flash_host_consts.vh"

// Function
// - Only one non-read function per bank; host issues nothing else.
// - After power-up host resets or toggles select before reading.
// - Host waits the wake-up delay after reset rises before reading.
// - Identifier voltage on bit 9; bit 0 picks maker or device word.
// - Host holds address bit 1 low for identifier reads.
// - Host writes with write low, select low, gate high.
// - Reset held low 500 ns aborts work; read mode within 20 us.
module flash_bus_host #(
	parameter ADDR_W = 19,
	parameter DATA_W = 16,
	parameter ACC_CYC = `ACC_DELAY_CYC,
	parameter WAKE_CYC = `WAKE_DELAY_CYC,
	parameter RST_DONE_CYC = `RESET_DONE_CYC
) (
	input wire mclk_in,
	input wire rstn_in,
	input wire req_in,
	input wire req_write_in,
	input wire req_id_in,
	input wire req_reset_in,
	input wire [ADDR_W-1:0] req_addr_in,
	input wire [DATA_W-1:0] req_wdata_in,
	input wire [DATA_W-1:0] dq_in,
	output reg busy_out,
	output reg done_out,
	output reg [DATA_W-1:0] rdata_out,
	output reg parity_ok_out,
	output reg [2:0] bank_out,
	output reg [ADDR_W-1:0] addr_out,
	output reg [DATA_W-1:0] dq_out,
	output reg dq_oe_n_out,
	output reg ce_n_out,
	output reg oe_n_out,
	output reg we_n_out,
	output reg reset_n_out,
	output reg identifier_high_voltage_out
);
	localparam S_IDLE = 3'h0;
	localparam S_READ = 3'h1;
	localparam S_WLOW = 3'h2;
	localparam S_WHIGH = 3'h3;
	localparam S_RLOW = 3'h4;
	localparam S_RWAIT = 3'h5;
	localparam S_WAKE = 3'h6;
	localparam S_DONE = 3'h7;
	localparam CW = 24;
	// Counts held in 32 bits and sliced to the counter width in each compare.
	localparam [31:0] WE_LOW_L = `WE_LOW_CYC;
	localparam [31:0] WE_HIGH_L = `WE_HIGH_CYC;
	localparam [31:0] RST_LOW_L = `RESET_LOW_CYC;

	reg [DATA_W-1:0] dq_s1_r;
	reg [DATA_W-1:0] dq_s2_r;
	reg [2:0] state_r;
	reg [CW-1:0] cnt_r;
	reg id_r;
	reg woke_r;

	always @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			dq_s1_r <= {DATA_W{1'b0}};
			dq_s2_r <= {DATA_W{1'b0}};
		end else begin
			dq_s1_r <= dq_in;
			dq_s2_r <= dq_s1_r;
		end
	end

	// Power-up reads are preceded by a flash reset, so no stale output.
	always @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			state_r <= S_RLOW;
			cnt_r <= {CW{1'b0}};
			id_r <= 1'b0;
			woke_r <= 1'b0;
			busy_out <= 1'b1;
			done_out <= 1'b0;
			rdata_out <= {DATA_W{1'b0}};
			parity_ok_out <= 1'b0;
			bank_out <= 3'h0;
			addr_out <= {ADDR_W{1'b0}};
			dq_out <= {DATA_W{1'b0}};
			dq_oe_n_out <= 1'b1;
			ce_n_out <= 1'b1;
			oe_n_out <= 1'b1;
			we_n_out <= 1'b1;
			reset_n_out <= 1'b0;
			identifier_high_voltage_out <= 1'b0;
		end else begin
			done_out <= 1'b0;
			case (state_r)
			S_IDLE: begin
				// Idle with select high and reset high is standby.
				ce_n_out <= 1'b1;
				oe_n_out <= 1'b1;
				we_n_out <= 1'b1;
				dq_oe_n_out <= 1'b1;
				identifier_high_voltage_out <= 1'b0;
				busy_out <= 1'b0;
				cnt_r <= {CW{1'b0}};
				// One operation at a time; requests outside idle are ignored.
				if (req_in) begin
					busy_out <= 1'b1;
					addr_out <= req_addr_in;
					// Bank is a plain slice of the address.
					bank_out <= req_addr_in[`BANK_MSB:`BANK_LSB];
					if (req_reset_in) begin
						reset_n_out <= 1'b0;
						state_r <= S_RLOW;
					end else if (req_write_in) begin
						// Address latches at the later falling edge.
						ce_n_out <= 1'b0;
						dq_out <= req_wdata_in;
						dq_oe_n_out <= 1'b0;
						state_r <= S_WLOW;
					end else begin
						id_r <= req_id_in;
						if (req_id_in) begin
							// Both banks enter autoselect here.
							identifier_high_voltage_out <= 1'b1;
							// Bit 1 low for proper codes.
							addr_out[`ID_PAGE_BIT] <= 1'b0;
						end
						// Select and gate low together enable data.
						ce_n_out <= 1'b0;
						oe_n_out <= 1'b0;
						state_r <= S_READ;
					end
				end
			end
			S_READ: begin
				// Address held stable; any sleep keeps data driven.
				// Wait covers address, select and gate delays.
				cnt_r <= cnt_r + 1'b1;
				// Two extra counts cover the two flops on the data pins.
				if (cnt_r >= ACC_CYC[CW-1:0] + 2'd2) begin
					rdata_out <= dq_s2_r;
					// Odd parity over the low byte of an identifier.
					parity_ok_out <= id_r ? ^dq_s2_r[`PARITY_DATA_BIT:0]
						: 1'b0;
					ce_n_out <= 1'b1;
					oe_n_out <= 1'b1;
					state_r <= S_DONE;
				end
			end
			S_WLOW: begin
				// Write strobe low with gate high.
				we_n_out <= 1'b0;
				cnt_r <= cnt_r + 1'b1;
				if (cnt_r == WE_LOW_L[CW-1:0]) begin
					// Write rises first so data latches on it.
					we_n_out <= 1'b1;
					cnt_r <= {CW{1'b0}};
					state_r <= S_WHIGH;
				end
			end
			S_WHIGH: begin
				ce_n_out <= 1'b1;
				cnt_r <= cnt_r + 1'b1;
				if (cnt_r == WE_HIGH_L[CW-1:0]) begin
					dq_oe_n_out <= 1'b1;
					state_r <= S_DONE;
				end
			end
			S_RLOW: begin
				// Reset low is standby and floats the flash outputs.
				reset_n_out <= 1'b0;
				ce_n_out <= 1'b1;
				cnt_r <= cnt_r + 1'b1;
				// Hold low past both the pulse and the abort time.
				if (cnt_r >= RST_DONE_CYC[CW-1:0] &&
					cnt_r >= RST_LOW_L[CW-1:0]) begin
					reset_n_out <= 1'b1;
					cnt_r <= {CW{1'b0}};
					state_r <= S_WAKE;
				end
			end
			S_WAKE: begin
				// No read until the wake-up delay has passed.
				cnt_r <= cnt_r + 1'b1;
				if (cnt_r >= WAKE_CYC[CW-1:0]) begin
					woke_r <= 1'b1;
					// Power-up wake idles quietly; a requested reset ends in done.
					state_r <= woke_r ? S_DONE : S_IDLE;
				end
			end
			S_DONE: begin
				done_out <= 1'b1;
				busy_out <= 1'b0;
				state_r <= S_IDLE;
			end
			default: state_r <= S_IDLE;
			endcase
		end
	end
endmodule

// *** testbench/flash_bus_host_monitor.sv ***
/* Checker for the flash host pins.
 Assumes it is bound to the host module and sees only its ports. */
`timescale 1ns/100ps
module bus_monitor(input wire mclk_in, rstn_in, done_out, ce_n_out,
	oe_n_out, we_n_out, dq_oe_n_out, reset_n_out,
	identifier_high_voltage_out, input wire [18:0] addr_out,
	input wire [2:0] bank_out);
	default clocking @(posedge mclk_in); endclocking
	default disable iff (!rstn_in);
	reg [7:0] low_r;
	// Saturates so a long reset cannot wrap below the minimum width.
	always @(posedge mclk_in or negedge rstn_in)
		if (!rstn_in) low_r <= 8'h00;
		else low_r <= reset_n_out ? 8'h00 : low_r + (low_r != 8'hff);
	bank_bits_a: assert property (bank_out == addr_out[18:16])
		else $error("bank differs from address bits");
	write_qual_a: assert property (!we_n_out |-> !ce_n_out && oe_n_out
		&& !dq_oe_n_out) else $error("write strobe badly qualified");
	read_gate_a: assert property (!oe_n_out |-> !ce_n_out && we_n_out
		&& dq_oe_n_out) else $error("read gate badly qualified");
	reset_idle_a: assert property (!reset_n_out |-> ce_n_out && oe_n_out
		&& we_n_out) else $error("strobes active in reset");
	reset_width_a: assert property ($rose(reset_n_out) |-> low_r >= 8'd100)
		else $error("flash reset too short");
	wake_wait_a: assert property ($rose(reset_n_out) |-> oe_n_out[*8])
		else $error("read before wake-up");
	id_page_a: assert property (identifier_high_voltage_out && !oe_n_out
		|-> !addr_out[1] && we_n_out) else $error("id read page bit set");
	we_width_a: assert property ($fell(we_n_out) |-> !we_n_out[*8])
		else $error("write pulse too short");
	data_hold_a: assert property ($rose(we_n_out) |-> !dq_oe_n_out
		&& !ce_n_out && $stable(addr_out)) else $error("data not held");
	read_done_a: assert property ($fell(oe_n_out) |-> ##[14:20] done_out)
		else $error("read did not finish");
	cover property (identifier_high_voltage_out && !oe_n_out);
	cover property ($rose(reset_n_out));
	cover property ($fell(we_n_out));
endmodule
bind flash_bus_host bus_monitor u_mon (.*);

// *** testbench/flash_model.sv ***
/* Flash partner: array words, identifier words, command latch.
 Assumes pins come from the host bench; no analogue timing. */
`timescale 1ns/100ps
module flash_model #(
	parameter logic [15:0] MAKER = 16'h0015, // Arbitrary value.
	parameter logic [15:0] DEVICE = 16'h2a8c // Arbitrary value.
) (
	input wire logic [18:0] addr_out,
	input wire logic [15:0] dq_out,
	input wire logic dq_oe_n_out, ce_n_out, oe_n_out, we_n_out,
	input wire logic reset_n_out, identifier_high_voltage_out,
	output logic [15:0] dq_in
);
	logic [15:0] val, held, cmd_d;
	logic [18:0] cmd_a;
	logic drive;
	assign drive = !ce_n_out && !oe_n_out && reset_n_out;
	assign val = identifier_high_voltage_out ?
		(addr_out[0] ? DEVICE : MAKER) : addr_out[15:0] ^ 16'hc3a5;
	always @* if (drive) held = val;
	// Released pins show the inverse so a stale sample cannot match.
	assign dq_in = !dq_oe_n_out ? dq_out : drive ? val : ~held;
	always @(negedge we_n_out or negedge ce_n_out)
		if (!we_n_out && !ce_n_out) cmd_a <= addr_out;
	always @(posedge we_n_out or posedge ce_n_out)
		if (!(we_n_out && ce_n_out)) cmd_d <= dq_in;
endmodule

// *** testbench/flash_bus_host_bench.sv ***
/* Bench for the flash host controller with the flash partner.
 Assumes a 200 MHz clock and a shortened flash reset count. */
`timescale 1ns/100ps
module flash_bus_host_bench;
	logic mclk_in, rstn_in, req_in, req_write_in, req_id_in, req_reset_in;
	logic [18:0] req_addr_in, addr_out;
	logic [15:0] req_wdata_in, dq_in, rdata_out, dq_out;
	logic busy_out, done_out, parity_ok_out, dq_oe_n_out, ce_n_out;
	logic oe_n_out, we_n_out, reset_n_out, identifier_high_voltage_out;
	logic [2:0] bank_out;
	int err_count = 0, comparisons = 0, cyc = 0, lat;
	flash_bus_host #(.RST_DONE_CYC(120)) u_dut (.*);
	flash_model u_mem (.*);
	initial begin
		mclk_in = 1'b0;
		forever #2.5 mclk_in = ~mclk_in;
	end
	task chk(input logic [31:0] got, exp);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task tally_and_finish;
		$display("comparisons %0d errors %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task run(input logic w, id, rs, input logic [18:0] a, input logic [15:0] d);
		@(posedge mclk_in);
		req_in <= 1'b1;
		{req_write_in, req_id_in, req_reset_in} <= {w, id, rs};
		req_addr_in <= a;
		req_wdata_in <= d;
		@(posedge mclk_in);
		req_in <= 1'b0;
		lat = 0;
		do begin
			@(negedge mclk_in);
			lat++;
		end while (done_out !== 1'b1 && lat < 300);
	endtask
	task t_read;
		run(0, 0, 0, 19'h5_1234, 16'h0000);
		chk(lat, 19);
		chk(rdata_out, 16'h1234 ^ 16'hc3a5);
		chk(parity_ok_out, 1'b0);
		chk(bank_out, 3'h5);
		$display("read test ended");
	endtask
	task t_id;
		for (int i = 0; i < 2; i++) begin
			run(0, 1, 0, 19'h7_fffe | i, 16'h0000);
			chk(rdata_out, i ? u_mem.DEVICE : u_mem.MAKER);
			chk(parity_ok_out, 1'b1);
		end
		$display("identifier test ended");
	endtask
	task t_write;
		run(1, 0, 0, 19'h2_0555, 16'h00aa);
		chk(lat, 20);
		chk(u_mem.cmd_a, 19'h2_0555);
		chk(u_mem.cmd_d, 16'h00aa);
		$display("write test ended");
	endtask
	task t_reset;
		run(0, 0, 1, 19'h0_0000, 16'h0000);
		chk(lat, 134);
		$display("reset test ended");
	endtask
	task t_refuse;
		fork
			run(0, 0, 0, 19'h3_0001, 16'h0000);
			begin
				repeat (4) @(posedge mclk_in);
				req_in <= 1'b1;
				req_addr_in <= 19'h0_0001;
				@(posedge mclk_in);
				req_in <= 1'b0;
			end
		join
		chk(addr_out, 19'h3_0001);
		chk(rdata_out, 16'h0001 ^ 16'hc3a5);
		$display("refusal test ended");
	endtask
	always @(posedge mclk_in) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			err_count++;
			tally_and_finish;
		end
	end
	initial begin
		{req_in, req_write_in, req_id_in, req_reset_in} = 4'h0;
		req_addr_in = 19'h0_0000;
		req_wdata_in = 16'h0000;
		rstn_in = 1'b0;
		repeat (8) @(posedge mclk_in);
		rstn_in <= 1'b1;
		do @(negedge mclk_in); while (busy_out !== 1'b0 && cyc < 2000);
		t_read;
		t_id;
		t_write;
		t_reset;
		t_read;
		t_refuse;
		tally_and_finish;
	end
endmodule
